// ---- hdl/csw_clock_switch.sv ----
// System clock source switch with idle and sleep mode control over APB.
//
// Summary of operation
// - Select field picks primary, secondary or internal.
// - Select write starts a source switch immediately.
// - Every reset clears the select field.
// - Frequency field picks internal block output rate.
// - Frequency change acts at once on internal clock.
// - Field zero: source bit picks divided-fast or RC.
// - Watchdog and monitor always run from RC.
// - Primary-ready needs timer done and primary active.
// - Internal-stable needs stable block driving clock.
// - Secondary-running shows secondary drives the clock.
// - At most one clock status flag set.
// - Sleep enters full sleep or idle per bit.
// - Idle request selecting disabled secondary is ignored.
// - Switch pauses two old, three new ticks.
// - Secondary switch stops primary, updates both flags.
// - Wake keeps clock, resumes processor after delay.
// - Peripheral clocks on secondary wait for its oscillator start.
// - Internal switch stops primary, clears primary-ready.
// - Fast oscillator on when field or bit set.
// - Stable flag stays set entering internal idle.
// - RC keeps running while watchdog or monitor enabled.
`timescale 1ns/10ps
`default_nettype none
module csw_clock_switch
  import csw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic prim_osc_clk,
  input wire logic sec_osc_clk,
  input wire logic lprc_clk,
  input wire logic wake_event,
  input wire logic wdt_enable,
  input wire logic fscm_enable,
  output logic sys_clk_en,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic wdt_clk_en,
  output logic fscm_clk_en,
  output logic prim_osc_en,
  output logic sec_osc_en,
  output logic fast_osc_en,
  output logic lprc_run
);

  // Software-visible control fields.
  logic [1:0] scs_q; // System clock select field.
  logic [2:0] ircf_q; // Internal frequency select field.
  logic idle_q; // Idle-on-sleep bit.
  logic lfsrc_q; // Low-frequency source select bit.
  logic [4:0] tune_q; // Tuning value, stored for software only.
  logic [7:0] t1_q; // Timer one control bits, bit 6 reads status.

  // Status flags.
  logic prim_rdy_q;
  logic int_stb_q;
  logic secondary_run_q;

  // Synchronised pin levels and their previous values for edge detect.
  logic [3:0] pin_sync;
  logic [3:0] pin_prev_q;
  logic prim_rise;
  logic sec_rise;
  logic lprc_rise;
  logic wake_rise;

  // Switch sequencer and mode state.
  csw_sw_t sw_q;
  csw_src_t cur_src_q;
  csw_src_t tgt_src;
  logic [1:0] sw_cnt_q;
  csw_mode_t mode_q;
  logic [7:0] wake_cnt_q;

  // Oscillator bookkeeping.
  logic [10:0] ost_cnt_q;
  logic ost_done_q;
  logic [7:0] stab_cnt_q;
  logic fast_stable_q;
  logic sec_started_q;
  logic post_tick;
  logic int_tick;
  logic cur_tick;
  logic fast_want;

  // APB decode.
  logic wr_fire;
  logic [7:0] rd_val;
  logic sleep_cmd;

  // Maps the select field onto a source; the lower bit is ignored
  // whenever the upper bit is set.
  function automatic csw_src_t scs_to_src(input logic [1:0] scs);
    csw_src_t s;
    s = CSW_SRC_PRIM;
    if (scs[1]) begin
      s = CSW_SRC_INT;
    end else if (scs[0]) begin
      s = CSW_SRC_SEC;
    end
    return s;
  endfunction

  // Picks the tick of one source.
  function automatic logic src_tick(input csw_src_t s, input logic p,
                                    input logic se, input logic in);
    logic t;
    t = p;
    if (s == CSW_SRC_SEC) begin
      t = se;
    end else if (s == CSW_SRC_INT) begin
      t = in;
    end
    return t;
  endfunction

  // True for the four mapped word addresses.
  function automatic logic addr_hit(input logic [7:0] a);
    return (a == CSW_ADDR_OSC_CTRL) || (a == CSW_ADDR_OSC_TUNE) ||
      (a == CSW_ADDR_TMR1_CTRL) || (a == CSW_ADDR_SLEEP_CMD);
  endfunction

  // Oscillator pins and the wake pin come from other domains.
  csw_sync #(
    .WIDTH(4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({wake_event, lprc_clk, sec_osc_clk, prim_osc_clk}),
    .sync_out(pin_sync)
  );

  // Fast internal oscillator with its postscaler.
  csw_postscaler u_post (
    .pclk(pclk),
    .presetn(presetn),
    .enable(fast_osc_en),
    .freq_sel(ircf_q),
    .tick(post_tick)
  );

  // Edge history of the synchronised levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_q <= 4'h0;
    end else begin
      pin_prev_q <= pin_sync;
    end
  end

  assign prim_rise = pin_sync[0] && !pin_prev_q[0] && prim_osc_en;
  assign sec_rise = pin_sync[1] && !pin_prev_q[1] && sec_osc_en;
  assign lprc_rise = pin_sync[2] && !pin_prev_q[2];
  assign wake_rise = pin_sync[3] && !pin_prev_q[3];

  // Internal block output: a zero field falls back to either the
  // divide-by-256 tap or the RC source.
  assign int_tick = ((ircf_q != 3'h0) || lfsrc_q) ? post_tick :
    lprc_rise;
  assign fast_want = (ircf_q != 3'h0) || lfsrc_q;
  assign tgt_src = scs_to_src(scs_q);
  assign cur_tick = src_tick(cur_src_q, prim_rise, sec_rise, int_tick);

  // APB write strobe and read data.
  assign wr_fire = psel && penable && pready && pwrite && !pslverr;
  assign sleep_cmd = wr_fire && (paddr == CSW_ADDR_SLEEP_CMD) &&
    pwdata[CSW_SC_SLEEP_BIT];

  always_comb begin
    rd_val = 8'h00;
    case (paddr)
      CSW_ADDR_OSC_CTRL: begin
        rd_val[CSW_OC_IDLE_BIT] = idle_q;
        rd_val[CSW_OC_IRCF_LSB +: 3] = ircf_q;
        rd_val[CSW_OC_PRDY_BIT] = prim_rdy_q;
        rd_val[CSW_OC_ISTB_BIT] = int_stb_q;
        rd_val[CSW_OC_SCS_LSB +: 2] = scs_q;
      end
      CSW_ADDR_OSC_TUNE: begin
        rd_val[CSW_OT_LFSRC_BIT] = lfsrc_q;
        rd_val[CSW_OT_TUNE_LSB +: 5] = tune_q;
      end
      CSW_ADDR_TMR1_CTRL: begin
        rd_val = t1_q;
        rd_val[CSW_T1_SRUN_BIT] = secondary_run_q;
      end
      CSW_ADDR_SLEEP_CMD: begin
        rd_val[3:0] = mode_q;
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  // Zero-wait APB slave: the answer is prepared in the setup cycle and
  // presented from flops during the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !addr_hit(paddr);
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // Control fields; any reset returns the select field to primary.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scs_q <= CSW_SCS_RST;
      ircf_q <= CSW_IRCF_RST;
      idle_q <= 1'b0;
      lfsrc_q <= 1'b0;
      tune_q <= CSW_TUNE_RST;
      t1_q <= CSW_T1_RST;
    end else if (wr_fire) begin
      case (paddr)
        CSW_ADDR_OSC_CTRL: begin
          idle_q <= pwdata[CSW_OC_IDLE_BIT];
          ircf_q <= pwdata[CSW_OC_IRCF_LSB +: 3];
          scs_q <= pwdata[CSW_OC_SCS_LSB +: 2];
        end
        CSW_ADDR_OSC_TUNE: begin
          lfsrc_q <= pwdata[CSW_OT_LFSRC_BIT];
          tune_q <= pwdata[CSW_OT_TUNE_LSB +: 5];
        end
        CSW_ADDR_TMR1_CTRL: begin
          t1_q <= pwdata[7:0];
        end
        default: begin
          t1_q <= t1_q;
        end
      endcase
    end
  end

  // Glitch-free switch: wait out two old-source ticks, hand over, then
  // let three new-source ticks pass before the clock is released. Since
  // ticks are sampled on pclk the pause is three to four new periods.
  // A source that never ticks stalls the switch; this is the long delay
  // software must avoid by starting the oscillator first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q <= CSW_SW_STEADY;
      cur_src_q <= CSW_SRC_PRIM;
      sw_cnt_q <= 2'h0;
    end else begin
      case (sw_q)
        CSW_SW_STEADY: begin
          if (tgt_src != cur_src_q) begin
            sw_q <= CSW_SW_OLD;
            sw_cnt_q <= 2'h0;
          end
        end
        CSW_SW_OLD: begin
          if (cur_tick) begin
            if (sw_cnt_q == CSW_OLD_TICKS - 2'h1) begin
              cur_src_q <= tgt_src;
              sw_q <= CSW_SW_NEW;
              sw_cnt_q <= 2'h0;
            end else begin
              sw_cnt_q <= sw_cnt_q + 2'h1;
            end
          end
        end
        CSW_SW_NEW: begin
          if (tgt_src != cur_src_q) begin
            // Software changed its mind mid-switch; start over.
            sw_q <= CSW_SW_OLD;
            sw_cnt_q <= 2'h0;
          end else if (cur_tick) begin
            if (sw_cnt_q == CSW_NEW_TICKS - 2'h1) begin
              sw_q <= CSW_SW_STEADY;
            end else begin
              sw_cnt_q <= sw_cnt_q + 2'h1;
            end
          end
        end
        default: begin
          sw_q <= CSW_SW_STEADY;
          sw_cnt_q <= 2'h0;
        end
      endcase
    end
  end

  // Mode sequencer for sleep, idle and the wake delay. Control fields are
  // not touched by wake, so the processor resumes on the idle clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= CSW_MD_RUN;
      wake_cnt_q <= 8'h00;
    end else begin
      case (mode_q)
        CSW_MD_RUN: begin
          if (sleep_cmd) begin
            if (!idle_q) begin
              mode_q <= CSW_MD_SLEEP;
            end else if (tgt_src == CSW_SRC_SEC &&
                         !t1_q[CSW_T1_SEN_BIT]) begin
              mode_q <= CSW_MD_RUN;
            end else begin
              mode_q <= CSW_MD_IDLE;
            end
          end
        end
        CSW_MD_IDLE, CSW_MD_SLEEP: begin
          if (wake_rise) begin
            mode_q <= CSW_MD_WAKE;
            wake_cnt_q <= 8'h00;
          end
        end
        CSW_MD_WAKE: begin
          if (wake_cnt_q == 8'(CSW_WAKE_CYC - 1)) begin
            mode_q <= CSW_MD_RUN;
          end else begin
            wake_cnt_q <= wake_cnt_q + 8'h01;
          end
        end
        default: begin
          mode_q <= CSW_MD_RUN;
        end
      endcase
    end
  end

  // Primary oscillator runs only while it is, or is about to be, the
  // source; leaving it shuts it down and restarts its start-up timer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_osc_en <= 1'b0;
      ost_cnt_q <= 11'h000;
      ost_done_q <= 1'b0;
    end else begin
      prim_osc_en <= (mode_q != CSW_MD_SLEEP) &&
        (cur_src_q == CSW_SRC_PRIM || tgt_src == CSW_SRC_PRIM);
      if (!prim_osc_en) begin
        ost_cnt_q <= 11'h000;
        ost_done_q <= 1'b0;
      end else if (prim_rise && !ost_done_q) begin
        if (ost_cnt_q == CSW_OST_TICKS - 11'h001) begin
          ost_done_q <= 1'b1;
        end else begin
          ost_cnt_q <= ost_cnt_q + 11'h001;
        end
      end
    end
  end

  // Fast oscillator enable and stabilisation timer. The timer only
  // restarts when the oscillator goes off, so a stable oscillator stays
  // stable across sleep entry.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_en <= 1'b0;
      stab_cnt_q <= 8'h00;
      fast_stable_q <= 1'b0;
    end else begin
      fast_osc_en <= fast_want;
      if (!fast_osc_en) begin
        stab_cnt_q <= 8'h00;
        fast_stable_q <= 1'b0;
      end else if (!fast_stable_q) begin
        if (stab_cnt_q == 8'(CSW_INT_STAB_CYC - 1)) begin
          fast_stable_q <= 1'b1;
        end else begin
          stab_cnt_q <= stab_cnt_q + 8'h01;
        end
      end
    end
  end

  // Secondary oscillator enable and start detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_osc_en <= 1'b0;
      sec_started_q <= 1'b0;
    end else begin
      sec_osc_en <= t1_q[CSW_T1_SEN_BIT];
      if (!sec_osc_en) begin
        sec_started_q <= 1'b0;
      end else if (sec_rise) begin
        sec_started_q <= 1'b1;
      end
    end
  end

  // Status flags; each demands its own source as the current one, so at
  // most one can be set, and none while RC drives the clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_rdy_q <= 1'b0;
      int_stb_q <= 1'b0;
      secondary_run_q <= 1'b0;
    end else begin
      prim_rdy_q <= ost_done_q && cur_src_q == CSW_SRC_PRIM &&
        sw_q == CSW_SW_STEADY;
      int_stb_q <= fast_stable_q && fast_want &&
        cur_src_q == CSW_SRC_INT;
      secondary_run_q <= sec_started_q &&
        cur_src_q == CSW_SRC_SEC;
    end
  end

  // Clock enables. The device clock is gated during a switch; the CPU
  // only runs in run mode; peripherals run in idle too, but are held off
  // while the secondary drives the clock before its oscillator has started.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_en <= 1'b0;
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= (sw_q == CSW_SW_STEADY) && cur_tick;
      cpu_clk_en <= (sw_q == CSW_SW_STEADY) && cur_tick &&
        mode_q == CSW_MD_RUN;
      periph_clk_en <= (sw_q == CSW_SW_STEADY) && cur_tick &&
        mode_q != CSW_MD_SLEEP &&
        !(cur_src_q == CSW_SRC_SEC && !sec_started_q);
    end
  end

  // Watchdog and clock monitor always tick from the RC source, and that
  // source is kept running whenever either of them needs it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_clk_en <= 1'b0;
      fscm_clk_en <= 1'b0;
      lprc_run <= 1'b0;
    end else begin
      wdt_clk_en <= lprc_rise && wdt_enable;
      fscm_clk_en <= lprc_rise && fscm_enable;
      lprc_run <= wdt_enable || fscm_enable ||
        ((cur_src_q == CSW_SRC_INT || tgt_src == CSW_SRC_INT) &&
         !fast_want);
    end
  end

endmodule
`default_nettype wire

// ---- hdl/csw_pkg.sv ----
// Constants, register map and state types for the system clock switch.
package csw_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0] CSW_ADDR_OSC_CTRL = 8'h00;
  localparam logic [7:0] CSW_ADDR_OSC_TUNE = 8'h04;
  localparam logic [7:0] CSW_ADDR_TMR1_CTRL = 8'h08;
  localparam logic [7:0] CSW_ADDR_SLEEP_CMD = 8'h0c;

  // Field positions in oscillator_control_reg.
  localparam int unsigned CSW_OC_IDLE_BIT = 7;
  localparam int unsigned CSW_OC_IRCF_LSB = 4;
  localparam int unsigned CSW_OC_PRDY_BIT = 3;
  localparam int unsigned CSW_OC_ISTB_BIT = 2;
  localparam int unsigned CSW_OC_SCS_LSB = 0;

  // Field positions in oscillator_tuning_reg.
  localparam int unsigned CSW_OT_LFSRC_BIT = 7;
  localparam int unsigned CSW_OT_TUNE_LSB = 0;

  // Field positions in timer_one_control_reg.
  localparam int unsigned CSW_T1_SRUN_BIT = 6;
  localparam int unsigned CSW_T1_SEN_BIT = 3;

  // Field position in the sleep command register.
  localparam int unsigned CSW_SC_SLEEP_BIT = 0;

  // Reset values of the writable fields.
  localparam logic [1:0] CSW_SCS_RST = 2'h0;
  localparam logic [2:0] CSW_IRCF_RST = 3'h0;
  localparam logic [4:0] CSW_TUNE_RST = 5'h00;
  localparam logic [7:0] CSW_T1_RST = 8'h00;

  // Clock switch pause, counted in ticks of the old and the new source.
  localparam logic [1:0] CSW_OLD_TICKS = 2'h2;
  localparam logic [1:0] CSW_NEW_TICKS = 2'h3;

  // Primary start-up timer length in primary oscillator ticks.
  localparam logic [10:0] CSW_OST_TICKS = 11'h400;

  // Rates and times, and the cycle counts derived from them.
  localparam int unsigned CSW_PCLK_MHZ = 200;
  localparam int unsigned CSW_FAST_OSC_MHZ = 8;
  localparam int unsigned CSW_FAST_DIV = CSW_PCLK_MHZ / CSW_FAST_OSC_MHZ;
  localparam int unsigned CSW_INT_STAB_NS = 1000;
  localparam int unsigned CSW_INT_STAB_CYC =
    (CSW_INT_STAB_NS * CSW_PCLK_MHZ + 999) / 1000;
  localparam int unsigned CSW_WAKE_DELAY_NS = 1000;
  localparam int unsigned CSW_WAKE_CYC =
    (CSW_WAKE_DELAY_NS * CSW_PCLK_MHZ + 999) / 1000;

  // Clock sources that can drive the device clock.
  typedef enum logic [1:0] {
    CSW_SRC_PRIM = 2'h0,
    CSW_SRC_SEC = 2'h1,
    CSW_SRC_INT = 2'h2
  } csw_src_t;

  // Operating mode of the processor and peripherals, one-hot.
  typedef enum logic [3:0] {
    CSW_MD_RUN = 4'h1,
    CSW_MD_IDLE = 4'h2,
    CSW_MD_SLEEP = 4'h4,
    CSW_MD_WAKE = 4'h8
  } csw_mode_t;

  // Glitch-free switch sequencer states, one-hot.
  typedef enum logic [2:0] {
    CSW_SW_STEADY = 3'h1,
    CSW_SW_OLD = 3'h2,
    CSW_SW_NEW = 3'h4
  } csw_sw_t;

endpackage

// ---- hdl/csw_sync.sv ----
// Two-stage synchroniser for a group of asynchronous levels.
`timescale 1ns/10ps
`default_nettype none
module csw_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage; read only by the second stage below.
  logic [WIDTH-1:0] meta_q;

  // Both stages clear to zero under reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/csw_postscaler.sv ----
// Fast internal oscillator model and its frequency postscaler.
`timescale 1ns/10ps
`default_nettype none
module csw_postscaler
  import csw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [2:0] freq_sel,
  output logic tick
);

  // The 8 MHz base rate is a divider on pclk, since the model has one clock.
  logic [4:0] base_cnt_q;
  logic base_tick;
  logic [7:0] post_cnt_q;

  // Mask of low postscaler bits that must all be set for an output tick.
  function automatic logic [7:0] div_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = 8'hff;
    if (sel != 3'h0) begin
      m = 8'(8'h7f >> sel);
    end
    return m;
  endfunction

  assign base_tick = enable && (base_cnt_q == 5'(CSW_FAST_DIV - 1));

  // Base divider; held at zero while the oscillator is off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt_q <= 5'h00;
    end else if (!enable || base_tick) begin
      base_cnt_q <= 5'h00;
    end else begin
      base_cnt_q <= base_cnt_q + 5'h01;
    end
  end

  // Postscaler counter, free running in base ticks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt_q <= 8'h00;
    end else if (!enable) begin
      post_cnt_q <= 8'h00;
    end else if (base_tick) begin
      post_cnt_q <= post_cnt_q + 8'h01;
    end
  end

  // A new select acts on the very next base tick, so a change is immediate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else begin
      tick <= base_tick &&
        ((post_cnt_q & div_mask(freq_sel)) == div_mask(freq_sel));
    end
  end

endmodule
`default_nettype wire

// ---- tb/csw_osc_model.sv ----
// Oscillator sources feeding the clock switch bench.
`timescale 1ns/10ps
`default_nettype none
module csw_osc_model #(
  parameter int SEC_STEPS = 120
) (
  input wire logic prim_osc_en,
  input wire logic sec_osc_en,
  input wire logic lprc_run,
  output logic prim_osc_clk,
  output logic sec_osc_clk,
  output logic lprc_clk
);
  int sec_age = 0; // Half periods since the crystal was enabled.
  // Periods sit off the 5 ns grid so no edge races the bench clock.
  // A stopped source rests low, as a gated oscillator does.
  always begin
    #11;
    prim_osc_clk = prim_osc_en && !prim_osc_clk;
  end
  // A slow crystal: it only starts well after its enable rises.
  always begin
    #17;
    sec_age = (sec_osc_en === 1'b1) ? sec_age + 1 : 0;
    sec_osc_clk = (sec_age > SEC_STEPS) && !sec_osc_clk;
  end
  always begin
    #23;
    lprc_clk = lprc_run && !lprc_clk;
  end
endmodule
`default_nettype wire

// ---- tb/csw_clock_switch_properties.sv ----
// Port-level assertions for the system clock switch.
`timescale 1ns/10ps
`default_nettype none
module csw_clock_switch_properties
  import csw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_clk_en,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic wdt_enable,
  input wire logic fscm_enable,
  input wire logic wdt_clk_en,
  input wire logic fscm_clk_en,
  input wire logic lprc_run
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // The slave never stretches a transfer.
  apb_answer_a:
    assert property (psel && !penable |=> pready)
    else $error("setup not answered next cycle");
  ready_pulse_a:
    assert property (pready |=> !pready)
    else $error("pready held two cycles");
  unmapped_err_a:
    assert property (pready && paddr > CSW_ADDR_SLEEP_CMD |-> pslverr)
    else $error("unmapped access not refused");
  err_data_a:
    assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  flags_one_a:
    assert property (pready && !pwrite && paddr == CSW_ADDR_OSC_CTRL
      |-> !(prdata[CSW_OC_PRDY_BIT] && prdata[CSW_OC_ISTB_BIT]))
    else $error("two clock status flags set");
  // Sources tick no faster than every fourth cycle, even mid switch.
  sys_gap_a:
    assert property (sys_clk_en |=> !sys_clk_en [*3])
    else $error("device clock glitch");
  cpu_tick_a:
    assert property (cpu_clk_en || periph_clk_en |-> sys_clk_en)
    else $error("core tick without device tick");
  rc_pair_a:
    assert property (wdt_enable && fscm_enable
      && $past(wdt_enable && fscm_enable) |-> wdt_clk_en == fscm_clk_en)
    else $error("watchdog and monitor ticks differ");
  rc_alive_a:
    assert property ((wdt_enable || fscm_enable) [*8] |-> lprc_run)
    else $error("rc stopped while needed");
  cover property (pready && pslverr);
  cover property (periph_clk_en && !cpu_clk_en);
  cover property (cpu_clk_en);
endmodule
bind csw_clock_switch csw_clock_switch_properties
  i_csw_clock_switch_properties (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the system clock switch.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import csw_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic wake_event = 1'b0;
  logic wdt_enable = 1'b0;
  logic fscm_enable = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, sys_clk_en, cpu_clk_en, periph_clk_en;
  logic wdt_clk_en, fscm_clk_en, prim_osc_en, sec_osc_en, fast_osc_en;
  logic lprc_run, prim_osc_clk, sec_osc_clk, lprc_clk;
  int err_count = 0;
  int n_checks = 0;
  int seed = 80852;
  int cyc = 0;
  int g, f, c_cpu, c_per, c_wdt;
  csw_clock_switch i_csw_clock_switch (.*);
  csw_osc_model i_csw_osc_model (.*);
  always #2.5 pclk = ~pclk;
  // Hang guard, sized well above the longest expected run.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, v);
    n_checks++;
    if (v !== e) begin
      err_count++;
      $display("wrong value %s: expected %h seen %h", n, e, v);
    end
  endtask
  // One APB transfer; an idle cycle follows so psel never toggles twice.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e,
                     input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, a, 32'h0);
      if (rd[b] === 1'b1) break;
    end
  endtask
  // Second of two tick gaps, so a rate change has settled.
  task automatic gap();
    repeat (2) begin
      do @(posedge pclk); while (sys_clk_en !== 1'b1);
    end
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (sys_clk_en !== 1'b1);
  endtask
  task automatic watch(input int n);
    c_cpu = 0;
    c_per = 0;
    c_wdt = 0;
    repeat (n) begin
      @(posedge pclk);
      c_cpu += (cpu_clk_en === 1'b1);
      c_per += (periph_clk_en === 1'b1);
      c_wdt += (wdt_clk_en === 1'b1);
    end
  endtask
  // The mode reads WAKE before the resume delay ends.
  task automatic wake();
    wake_event <= 1'b1;
    repeat (8) @(posedge pclk);
    rdc(CSW_ADDR_SLEEP_CMD, 32'hf, 32'h8, "wake mode");
    wake_event <= 1'b0;
    poll(CSW_ADDR_SLEEP_CMD, 0);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(CSW_ADDR_OSC_CTRL, 32'hff, 32'h0, "ctrl reset");
    rdc(CSW_ADDR_TMR1_CTRL, 32'hff, 32'h0, "t1 reset");
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, err);
    wdt_enable <= 1'b1;
    fscm_enable <= 1'b1;
    repeat (3) begin
      f = $random(seed) & 32'h1f;
      wr(CSW_ADDR_OSC_TUNE, f);
      rdc(CSW_ADDR_OSC_TUNE, 32'hff, f, "tune");
    end
    poll(CSW_ADDR_OSC_CTRL, CSW_OC_PRDY_BIT);
    chk("prim ready", 32'h1, rd[CSW_OC_PRDY_BIT]);
    $display("test registers done");
    wr(CSW_ADDR_OSC_CTRL, 32'h72);
    repeat (2) @(posedge pclk);
    g = 0;
    while (sys_clk_en !== 1'b1) begin
      @(posedge pclk);
      g++;
    end
    chk("pause", 32'h1, g >= 60 && g <= 160);
    poll(CSW_ADDR_OSC_CTRL, CSW_OC_ISTB_BIT);
    chk("int stable", 32'h1, rd[CSW_OC_ISTB_BIT]);
    chk("prim ready off", 32'h0, rd[CSW_OC_PRDY_BIT]);
    chk("prim osc off", 32'h0, prim_osc_en);
    chk("fast osc on", 32'h1, fast_osc_en);
    repeat (3) begin
      f = 1 + $unsigned($random(seed)) % 7;
      wr(CSW_ADDR_OSC_CTRL, 32'h02 | f << 4);
      gap();
      chk("int rate", CSW_FAST_DIV << (7 - f), g);
    end
    wr(CSW_ADDR_OSC_TUNE, 32'h80);
    wr(CSW_ADDR_OSC_CTRL, 32'h02);
    gap();
    chk("lf rate", CSW_FAST_DIV * 256, g);
    wr(CSW_ADDR_OSC_TUNE, 32'h00);
    repeat (4) @(posedge pclk);
    rdc(CSW_ADDR_OSC_CTRL, 32'h04, 32'h0, "stable off");
    chk("fast osc off", 32'h0, fast_osc_en);
    wr(CSW_ADDR_OSC_CTRL, 32'hf2);
    poll(CSW_ADDR_OSC_CTRL, CSW_OC_ISTB_BIT);
    $display("test internal clock done");
    wr(CSW_ADDR_SLEEP_CMD, 32'h1);
    rdc(CSW_ADDR_OSC_CTRL, 32'h04, 32'h04, "stable kept");
    rdc(CSW_ADDR_SLEEP_CMD, 32'hf, 32'h2, "idle mode");
    watch(200);
    chk("idle cpu", 32'h0, c_cpu);
    chk("idle periph", 32'h1, c_per > 0);
    chk("rc runs", 32'h1, c_wdt > 0 && lprc_run);
    wake();
    rdc(CSW_ADDR_OSC_CTRL, 32'hf3, 32'hf2, "ctrl kept");
    watch(100);
    chk("cpu resumes", 32'h1, c_cpu > 0);
    $display("test internal idle done");
    wr(CSW_ADDR_OSC_CTRL, 32'hf1);
    wr(CSW_ADDR_SLEEP_CMD, 32'h1);
    rdc(CSW_ADDR_SLEEP_CMD, 32'hf, 32'h1, "sleep ignored");
    wr(CSW_ADDR_TMR1_CTRL, 32'h08);
    wr(CSW_ADDR_SLEEP_CMD, 32'h1);
    watch(100);
    chk("periph held", 32'h0, c_per);
    chk("sec osc on", 32'h1, sec_osc_en);
    poll(CSW_ADDR_TMR1_CTRL, CSW_T1_SRUN_BIT);
    chk("sec running", 32'h1, rd[CSW_T1_SRUN_BIT]);
    chk("prim off", 32'h0, prim_osc_en);
    rdc(CSW_ADDR_SLEEP_CMD, 32'hf, 32'h2, "secondary_idle");
    watch(200);
    chk("sec periph", 32'h1, c_per > 0 && c_cpu == 0);
    wake();
    $display("test secondary idle done");
    wr(CSW_ADDR_OSC_CTRL, 32'h71);
    wr(CSW_ADDR_SLEEP_CMD, 32'h1);
    rdc(CSW_ADDR_SLEEP_CMD, 32'hf, 32'h4, "sleep mode");
    watch(100);
    chk("sleep periph", 32'h0, c_per);
    wake();
    $display("test full sleep done");
    close_out();
  end
endmodule
`default_nettype wire
